// ### core/pmwc_pkg.sv
package pmwc_pkg;

    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_CTL = 8'h00;
    localparam logic [7:0] OFS_IV = 8'h04;
    localparam logic [7:0] OFS_MOD = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_IEN = 8'h14;
    localparam logic [7:0] OFS_ICLR = 8'h18;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int CTL_FLAG = 0;
    localparam int CTL_IE = 1;
    localparam int CTL_SR = 2;
    localparam int CTL_SS_LO = 4;
    localparam int CTL_PS_LO = 8;
    localparam int EVT_OVF = 0;
    localparam int EVT_SRST = 1;
    localparam int EVT_W = 2;

    // --------------------------------------------------------------
    // reset and read values
    // --------------------------------------------------------------
    localparam logic [15:0] MOD_RESET = 16'hbeef;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] IV_NONE = 16'h0000;
    localparam logic [15:0] IV_OVF = 16'h0002;

    // --------------------------------------------------------------
    // predivider terminal counts (ratio minus one)
    // --------------------------------------------------------------
    localparam logic [9:0] LAST_D1 = 10'd0;
    localparam logic [9:0] LAST_D10 = 10'd9;
    localparam logic [9:0] LAST_D100 = 10'd99;
    localparam logic [9:0] LAST_D1000 = 10'd999;
    localparam logic [9:0] LAST_D16 = 10'd15;
    localparam logic [9:0] LAST_D64 = 10'd63;
    localparam logic [9:0] LAST_D256 = 10'd255;
    localparam logic [9:0] LAST_D1024 = 10'd1023;

    typedef enum logic [1:0] {
        PMWC_SS_OFF = 2'b00,
        PMWC_SS_DEV = 2'b01,
        PMWC_SS_XTAL = 2'b10,
        PMWC_SS_VLO = 2'b11
    } pmwc_src_t;

    typedef enum logic [2:0] {
        PMWC_PS_D1 = 3'b000,
        PMWC_PS_D10 = 3'b001,
        PMWC_PS_D100 = 3'b010,
        PMWC_PS_D1000 = 3'b011,
        PMWC_PS_D16 = 3'b100,
        PMWC_PS_D64 = 3'b101,
        PMWC_PS_D256 = 3'b110,
        PMWC_PS_D1024 = 3'b111
    } pmwc_div_t;

    typedef enum logic [2:0] {
        PMWC_PM_ACTIVE = 3'b000,
        PMWC_PM_LOW_POWER_MODE_0 = 3'b001,
        PMWC_PM_LPM1 = 3'b010,
        PMWC_PM_LPM2 = 3'b011,
        PMWC_PM_LOW_POWER_MODE_3 = 3'b100,
        PMWC_PM_SHUT_A = 3'b101,
        PMWC_PM_SHUT_B = 3'b110
    } pmwc_pwr_t;

endpackage

// ### core/pmwc_tick_if.sv
interface pmwc_tick_if;
    logic src_tick;
    logic div_tick;
    logic div_clr;
    logic [2:0] div_sel;

    modport gate (output src_tick);
    modport div (input src_tick, input div_sel, input div_clr, output div_tick);
    modport core (input div_tick, output div_sel, output div_clr);
endinterface

// ### core/pmwc_src_gate.sv
module pmwc_src_gate #(
    parameter bit DEV_IS_AUX = 1'b0
) (
    input logic clk_sys,
    input logic rst_b,
    input logic src_subsystem,
    input logic src_auxiliary,
    input logic src_crystal,
    input logic src_very_low_osc,
    input logic [1:0] clock_source_select,
    input logic [2:0] pwr_mode,
    pmwc_tick_if.gate tk
);

    // --------------------------------------------------------------
    // which source may run in which power mode
    // --------------------------------------------------------------
    function automatic logic mode_ok(input logic [1:0] ss, input logic [2:0] pm, input logic aux);
        mode_ok = 1'b0;
        if (pm == pmwc_pkg::PMWC_PM_SHUT_B) begin
            mode_ok = 1'b0;
        end else if (ss == pmwc_pkg::PMWC_SS_XTAL || ss == pmwc_pkg::PMWC_SS_VLO) begin
            mode_ok = 1'b1;
        end else if (ss == pmwc_pkg::PMWC_SS_DEV && pm != pmwc_pkg::PMWC_PM_SHUT_A) begin
            if (aux) begin
                mode_ok = (pm <= pmwc_pkg::PMWC_PM_LOW_POWER_MODE_3);
            end else begin
                mode_ok = (pm <= pmwc_pkg::PMWC_PM_LOW_POWER_MODE_0);
            end
        end
    endfunction

    logic sel_lvl;
    logic sel_prev;

    always_comb begin
        sel_lvl = 1'b0;
        case (clock_source_select)
            pmwc_pkg::PMWC_SS_DEV: sel_lvl = DEV_IS_AUX ? src_auxiliary : src_subsystem;
            pmwc_pkg::PMWC_SS_XTAL: sel_lvl = src_crystal;
            pmwc_pkg::PMWC_SS_VLO: sel_lvl = src_very_low_osc;
            default: sel_lvl = 1'b0;
        endcase
    end

    // a source switch may look like an edge; software resets after it
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sel_prev <= 1'b0;
        end else begin
            sel_prev <= sel_lvl;
        end
    end

    assign tk.src_tick = sel_lvl & ~sel_prev & mode_ok(clock_source_select, pwr_mode, DEV_IS_AUX);

    a_shut_b_stop: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pwr_mode == pmwc_pkg::PMWC_PM_SHUT_B |-> !tk.src_tick)
        else $error("source tick in deepest shutdown");
    a_shut_a_dev: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (pwr_mode == pmwc_pkg::PMWC_PM_SHUT_A && clock_source_select == pmwc_pkg::PMWC_SS_DEV)
        |-> !tk.src_tick)
        else $error("device clock ticked in shutdown a");

endmodule

// ### core/pmwc_predivider.sv
module pmwc_predivider #(
    parameter int CNT_W = 10
) (
    input logic clk_sys,
    input logic rst_b,
    pmwc_tick_if.div tk
);

    function automatic logic [9:0] div_last(input logic [2:0] sel);
        div_last = pmwc_pkg::LAST_D1;
        case (sel)
            pmwc_pkg::PMWC_PS_D10: div_last = pmwc_pkg::LAST_D10;
            pmwc_pkg::PMWC_PS_D100: div_last = pmwc_pkg::LAST_D100;
            pmwc_pkg::PMWC_PS_D1000: div_last = pmwc_pkg::LAST_D1000;
            pmwc_pkg::PMWC_PS_D16: div_last = pmwc_pkg::LAST_D16;
            pmwc_pkg::PMWC_PS_D64: div_last = pmwc_pkg::LAST_D64;
            pmwc_pkg::PMWC_PS_D256: div_last = pmwc_pkg::LAST_D256;
            pmwc_pkg::PMWC_PS_D1024: div_last = pmwc_pkg::LAST_D1024;
            default: div_last = pmwc_pkg::LAST_D1;
        endcase
    endfunction

    logic [CNT_W-1:0] pre_cnt;
    logic at_last;

    assign at_last = (pre_cnt >= CNT_W'(div_last(tk.div_sel)));

    always_ff @(posedge clk_sys) begin
        if (!rst_b || tk.div_clr) begin
            pre_cnt <= '0;
        end else if (tk.src_tick) begin
            pre_cnt <= at_last ? '0 : CNT_W'(pre_cnt + 1'b1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || tk.div_clr) begin
            tk.div_tick <= 1'b0;
        end else begin
            tk.div_tick <= tk.src_tick & at_last;
        end
    end

    a_pass_direct: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tk.div_sel == pmwc_pkg::PMWC_PS_D1 && tk.src_tick && !tk.div_clr) |=> tk.div_tick)
        else $error("passthrough did not forward the source tick");

endmodule

// ### core/pmwc_top.sv
// Implementation choices: the address map and the APB slave port.
module pmwc_top #(
    parameter bit DEV_IS_AUX = 1'b0,
    parameter int PRE_W = 10
) (
    input logic clk_sys,
    input logic rst_b,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic src_subsystem,
    input logic src_auxiliary,
    input logic src_crystal,
    input logic src_very_low_osc,
    input logic [2:0] pwr_mode,
    output logic irq,
    output logic overflow_trigger
);

    // --------------------------------------------------------------
    // register and state storage
    // --------------------------------------------------------------
    logic overflow_irq_enable;
    logic [1:0] clock_source_select;
    logic [2:0] predivider_select;
    logic [15:0] modulo_value;
    logic [15:0] shadow;
    logic [15:0] count;
    logic overflow_flag;
    logic [pmwc_pkg::EVT_W-1:0] evt_stat;
    logic [pmwc_pkg::EVT_W-1:0] evt_en;

    // --------------------------------------------------------------
    // bus phases
    // --------------------------------------------------------------
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic srst;
    logic ovf;
    logic next_irq;

    pmwc_tick_if tk ();

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = 1'b0;
        if (a == pmwc_pkg::OFS_CTL) begin
            is_mapped = 1'b1;
        end else if (a == pmwc_pkg::OFS_IV) begin
            is_mapped = 1'b1;
        end else if (a == pmwc_pkg::OFS_MOD) begin
            is_mapped = 1'b1;
        end else if (a == pmwc_pkg::OFS_CNT) begin
            is_mapped = 1'b1;
        end else if (a == pmwc_pkg::OFS_STAT) begin
            is_mapped = 1'b1;
        end else if (a == pmwc_pkg::OFS_IEN) begin
            is_mapped = 1'b1;
        end else if (a == pmwc_pkg::OFS_ICLR) begin
            is_mapped = 1'b1;
        end
    endfunction

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite & is_mapped(paddr);
    assign rd = access & ~pwrite;

    // zero wait states: read data is caught in the setup cycle
    assign pready = access;
    assign pslverr = access & ~is_mapped(paddr);

    // --------------------------------------------------------------
    // clock source, gating and predivider
    // --------------------------------------------------------------
    pmwc_src_gate #(
        .DEV_IS_AUX(DEV_IS_AUX)
    ) u_gate (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .src_subsystem(src_subsystem),
        .src_auxiliary(src_auxiliary),
        .src_crystal(src_crystal),
        .src_very_low_osc(src_very_low_osc),
        .clock_source_select(clock_source_select),
        .pwr_mode(pwr_mode),
        .tk(tk.gate)
    );

    pmwc_predivider #(
        .CNT_W(PRE_W)
    ) u_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tk(tk.div)
    );

    assign tk.div_sel = predivider_select;
    // soft reset also restarts the divider phase
    assign tk.div_clr = srst;

    // --------------------------------------------------------------
    // control register
    // --------------------------------------------------------------
    assign srst = wr & (paddr == pmwc_pkg::OFS_CTL) & pwdata[pmwc_pkg::CTL_SR];

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            overflow_irq_enable <= 1'b0;
            clock_source_select <= pmwc_pkg::PMWC_SS_OFF;
            predivider_select <= pmwc_pkg::PMWC_PS_D1;
        end else if (wr && paddr == pmwc_pkg::OFS_CTL) begin
            overflow_irq_enable <= pwdata[pmwc_pkg::CTL_IE];
            clock_source_select <= pwdata[pmwc_pkg::CTL_SS_LO +: 2];
            predivider_select <= pwdata[pmwc_pkg::CTL_PS_LO +: 3];
        end
    end

    // --------------------------------------------------------------
    // modulo and shadow
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            modulo_value <= pmwc_pkg::MOD_RESET;
        end else if (wr && paddr == pmwc_pkg::OFS_MOD) begin
            modulo_value <= pwdata[15:0];
        end
    end

    // the shadow takes the modulo value only on an overflow or a soft reset, so a modulo write does not disturb the count
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            shadow <= pmwc_pkg::MOD_RESET;
        end else if (ovf || srst) begin
            shadow <= modulo_value;
        end
    end

    // --------------------------------------------------------------
    // counter and compare
    // --------------------------------------------------------------
    assign ovf = tk.div_tick & (count == shadow) & ~srst;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            count <= pmwc_pkg::CNT_RESET;
        end else if (srst) begin
            count <= pmwc_pkg::CNT_RESET;
        end else if (ovf) begin
            count <= pmwc_pkg::CNT_RESET;
        end else if (tk.div_tick) begin
            count <= 16'(count + 16'h0001);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            overflow_trigger <= 1'b0;
        end else begin
            overflow_trigger <= ovf;
        end
    end

    // --------------------------------------------------------------
    // overflow flag and event status
    // --------------------------------------------------------------
    // clear only when the read returned the flag; a set in the same cycle wins
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            overflow_flag <= 1'b0;
        end else if (ovf) begin
            overflow_flag <= 1'b1;
        end else if (rd && paddr == pmwc_pkg::OFS_IV && prdata[1]) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            evt_stat <= '0;
        end else begin
            for (int i = 0; i < pmwc_pkg::EVT_W; i++) begin
                if ((i == pmwc_pkg::EVT_OVF && ovf) || (i == pmwc_pkg::EVT_SRST && srst)) begin
                    evt_stat[i] <= 1'b1;
                end else if (wr && paddr == pmwc_pkg::OFS_ICLR && pwdata[i]) begin
                    evt_stat[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            evt_en <= '0;
        end else if (wr && paddr == pmwc_pkg::OFS_IEN) begin
            evt_en <= pwdata[pmwc_pkg::EVT_W-1:0];
        end
    end

    // --------------------------------------------------------------
    // interrupt output
    // --------------------------------------------------------------
    assign next_irq = (overflow_flag & overflow_irq_enable) | (|(evt_stat & evt_en));

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // --------------------------------------------------------------
    // read data, caught in the setup cycle
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            if (paddr == pmwc_pkg::OFS_CTL) begin
                prdata <= 32'h0000_0000;
                prdata[pmwc_pkg::CTL_FLAG] <= overflow_flag;
                prdata[pmwc_pkg::CTL_IE] <= overflow_irq_enable;
                prdata[pmwc_pkg::CTL_SS_LO +: 2] <= clock_source_select;
                prdata[pmwc_pkg::CTL_PS_LO +: 3] <= predivider_select;
            end else if (paddr == pmwc_pkg::OFS_IV) begin
                prdata <= {16'h0000, overflow_flag ? pmwc_pkg::IV_OVF : pmwc_pkg::IV_NONE};
            end else if (paddr == pmwc_pkg::OFS_MOD) begin
                prdata <= {16'h0000, modulo_value};
            end else if (paddr == pmwc_pkg::OFS_CNT) begin
                prdata <= {16'h0000, count};
            end else if (paddr == pmwc_pkg::OFS_STAT) begin
                prdata <= {30'h0000_0000, evt_stat};
            end else if (paddr == pmwc_pkg::OFS_IEN) begin
                prdata <= {30'h0000_0000, evt_en};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_wrap_to_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ovf |=> (count == 16'h0000) && overflow_trigger)
        else $error("overflow did not clear the count");

    a_shadow_reload: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ovf || srst) |=> shadow == $past(modulo_value))
        else $error("shadow did not reload from modulo");

    a_srst_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
        srst |=> (count == 16'h0000) && !overflow_trigger)
        else $error("soft reset left count or pulsed trigger");

    a_flag_set_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ovf |=> overflow_flag ##1 (overflow_flag || $past(rd && paddr == pmwc_pkg::OFS_IV)))
        else $error("overflow flag lost without vector read");

    a_trig_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
        overflow_trigger |=> !overflow_trigger)
        else $error("trigger longer than one cycle");

    a_irq_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!overflow_irq_enable && evt_en == '0) |=> !irq)
        else $error("interrupt without enable");

    a_cnt_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tk.div_tick && !ovf && !srst) |=> count == 16'($past(count) + 16'h0001))
        else $error("count did not step by one");

    a_cnt_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!tk.div_tick && !srst) |=> $stable(count))
        else $error("count moved without a tick");

    a_cnt_ro: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr && paddr == pmwc_pkg::OFS_CNT && !tk.div_tick) |=> $stable(count))
        else $error("count taken from a bus write");

    a_flag_sets: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ovf |=> overflow_flag)
        else $error("overflow did not set the flag");

    a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rd && paddr == pmwc_pkg::OFS_IV && prdata[1] && !ovf) |=> !overflow_flag)
        else $error("vector read left the flag set");

    a_flag_keep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (overflow_flag && !(rd && paddr == pmwc_pkg::OFS_IV)) |=> overflow_flag)
        else $error("flag dropped without a vector read");

    a_srst_no_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (srst && !overflow_flag) |=> !overflow_flag)
        else $error("soft reset raised the flag");

    a_mod_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr && paddr == pmwc_pkg::OFS_MOD) |=> modulo_value == $past(pwdata[15:0]))
        else $error("modulo write lost");

    // shadow may only move on a reload, else a rewrite would cut the period short
    a_shadow_still: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(ovf || srst) |=> $stable(shadow))
        else $error("shadow changed outside a reload");

    a_trig_cause: assert property (@(posedge clk_sys) disable iff (!rst_b)
        overflow_trigger |-> $past(tk.div_tick && count == shadow && !srst))
        else $error("trigger without a compare match");

    a_irq_raise: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (overflow_flag && overflow_irq_enable) |=> irq)
        else $error("enabled flag gave no interrupt");

    a_src_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr && paddr == pmwc_pkg::OFS_CTL) |=> clock_source_select == $past(pwdata[pmwc_pkg::CTL_SS_LO +: 2]))
        else $error("source select write lost");

    a_div_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr && paddr == pmwc_pkg::OFS_CTL) |=> predivider_select == $past(pwdata[pmwc_pkg::CTL_PS_LO +: 3]))
        else $error("predivider select write lost");

endmodule

// ### test/periodic_modulo_wakeup_counter_bench.sv
module periodic_modulo_wakeup_counter_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic src_lvl = 1'b0;
    logic [2:0] pwr_mode = 3'h0;
    logic irq;
    logic overflow_trigger;
    logic [31:0] rd;
    logic [31:0] prdata_aux;
    logic [31:0] rd_aux;
    logic err;
    int mismatches = 0;
    int total_checks = 0;
    int trig_cnt = 0;
    int ratio [8] = '{1, 10, 100, 1000, 16, 64, 256, 1024};

    // all four sources share one level: the select alone decides which one counts
    pmwc_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_subsystem(src_lvl), .src_auxiliary(src_lvl), .src_crystal(src_lvl),
        .src_very_low_osc(src_lvl), .pwr_mode(pwr_mode), .irq(irq), .overflow_trigger(overflow_trigger));

    // second copy runs its device source from the auxiliary clock
    pmwc_top #(.DEV_IS_AUX(1'b1)) dut_aux (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_aux), .pready(), .pslverr(),
        .src_subsystem(src_lvl), .src_auxiliary(src_lvl), .src_crystal(src_lvl),
        .src_very_low_osc(src_lvl), .pwr_mode(pwr_mode), .irq(), .overflow_trigger());

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (overflow_trigger === 1'b1) trig_cnt++;
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic summarize();
        if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            summarize();
        end
        rd = prdata;
        rd_aux = prdata_aux;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        cmp32(rd, exp);
    endtask

    // trailing idle cycles let the divided tick land before any read
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            src_lvl <= 1'b1;
            @(posedge clk_sys);
            src_lvl <= 1'b0;
        end
        repeat (6) @(posedge clk_sys);
    endtask

    function automatic logic [31:0] ctl(logic [1:0] ss, logic [2:0] ps, logic ie, logic sr);
        return (32'(ss) << pmwc_pkg::CTL_SS_LO) | (32'(ps) << pmwc_pkg::CTL_PS_LO)
            | (32'(ie) << pmwc_pkg::CTL_IE) | (32'(sr) << pmwc_pkg::CTL_SR);
    endfunction

    // soft reset after the select write: a select change may give a stray tick
    task automatic cfg(input logic [1:0] ss, input logic [2:0] ps, input logic ie);
        wr(pmwc_pkg::OFS_CTL, ctl(ss, ps, ie, 1'b0));
        wr(pmwc_pkg::OFS_CTL, ctl(ss, ps, ie, 1'b1));
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic test_reset();
        rdc(pmwc_pkg::OFS_MOD, 32'h0000_beef);
        rdc(pmwc_pkg::OFS_IV, 32'h0000_0000);
        wr(pmwc_pkg::OFS_CNT, 32'h0000_1234);
        rdc(pmwc_pkg::OFS_CNT, 32'h0000_0000);
        apb(1'b0, 8'h1c, 32'h0000_0000);
        cmp1(err, 1'b1);
        cmp32(rd, 32'h0000_0000);
    endtask

    task automatic test_gating();
        logic run;
        for (int m = 0; m < 7; m++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge clk_sys);
                pwr_mode <= 3'(m);
                cfg(2'(s), 3'd0, 1'b0);
                tick(3);
                run = (s == 1) ? (m <= 1) : (s > 1 && m <= 5);
                rdc(pmwc_pkg::OFS_CNT, run ? 32'h0000_0003 : 32'h0000_0000);
                run = (s == 1) ? (m <= 4) : (s > 1 && m <= 5);
                cmp32(rd_aux, run ? 32'h0000_0003 : 32'h0000_0000);
            end
        end
        @(posedge clk_sys);
        pwr_mode <= 3'h0;
    endtask

    task automatic test_overflow();
        int t0;
        wr(pmwc_pkg::OFS_MOD, 32'h0000_0003);
        cfg(2'd2, 3'd0, 1'b1);
        apb(1'b0, pmwc_pkg::OFS_IV, 32'h0000_0000);
        t0 = trig_cnt;
        tick(3);
        rdc(pmwc_pkg::OFS_CNT, 32'h0000_0003);
        cmp1(irq, 1'b0);
        tick(1);
        rdc(pmwc_pkg::OFS_CNT, 32'h0000_0000);
        cmp32(32'(trig_cnt - t0), 32'h0000_0001);
        cmp1(irq, 1'b1);
        rdc(pmwc_pkg::OFS_CTL, ctl(2'd2, 3'd0, 1'b1, 1'b0) | 32'h0000_0001);
        rdc(pmwc_pkg::OFS_IV, 32'(pmwc_pkg::IV_OVF));
        rdc(pmwc_pkg::OFS_IV, 32'(pmwc_pkg::IV_NONE));
        cmp1(irq, 1'b0);
        tick(2);
        wr(pmwc_pkg::OFS_MOD, 32'h0000_0005);
        rdc(pmwc_pkg::OFS_CNT, 32'h0000_0002);
        tick(2);
        rdc(pmwc_pkg::OFS_CNT, 32'h0000_0000);
        tick(5);
        rdc(pmwc_pkg::OFS_CNT, 32'h0000_0005);
        tick(1);
        rdc(pmwc_pkg::OFS_CNT, 32'h0000_0000);
        cmp32(32'(trig_cnt - t0), 32'h0000_0003);
        apb(1'b0, pmwc_pkg::OFS_IV, 32'h0000_0000);
        tick(2);
        wr(pmwc_pkg::OFS_CTL, ctl(2'd2, 3'd0, 1'b1, 1'b1));
        rdc(pmwc_pkg::OFS_CNT, 32'h0000_0000);
        rdc(pmwc_pkg::OFS_IV, 32'h0000_0000);
        cmp32(32'(trig_cnt - t0), 32'h0000_0003);
    endtask

    task automatic test_events();
        cfg(2'd2, 3'd0, 1'b0);
        wr(pmwc_pkg::OFS_ICLR, 32'h0000_0003);
        rdc(pmwc_pkg::OFS_STAT, 32'h0000_0000);
        tick(6);
        rdc(pmwc_pkg::OFS_STAT, 32'h0000_0001);
        cmp1(irq, 1'b0);
        wr(pmwc_pkg::OFS_IEN, 32'h0000_0001);
        rdc(pmwc_pkg::OFS_IEN, 32'h0000_0001);
        cmp1(irq, 1'b1);
        wr(pmwc_pkg::OFS_IEN, 32'h0000_0000);
        rdc(pmwc_pkg::OFS_IEN, 32'h0000_0000);
        cmp1(irq, 1'b0);
        wr(pmwc_pkg::OFS_ICLR, 32'h0000_0001);
        rdc(pmwc_pkg::OFS_STAT, 32'h0000_0000);
    endtask

    // one short, then one more: catches a divider that is off by one
    task automatic test_divider();
        wr(pmwc_pkg::OFS_MOD, 32'h0000_0100);
        for (int p = 0; p < 8; p++) begin
            cfg(2'd2, 3'(p), 1'b0);
            tick(2 * ratio[p] - 1);
            rdc(pmwc_pkg::OFS_CNT, 32'h0000_0001);
            tick(1);
            rdc(pmwc_pkg::OFS_CNT, 32'h0000_0002);
        end
    endtask

    // --------------------------------------------------------------
    // sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        test_reset();
        test_gating();
        test_overflow();
        test_events();
        test_divider();
        summarize();
    end

    initial begin
        #200_000;
        mismatches++;
        summarize();
    end
endmodule
